// file: common/prescaler_pkg.sv
// Package for the shared timer prescaler and clock-select front end.
// Assumes a single 50 MHz clock and an APB register slave with 32-bit data.
package prescaler_pkg;

   // Register byte offsets.
   localparam logic [7:0] SYNC_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] SEL0_OFFSET = 8'h04;
   localparam logic [7:0] SEL1_OFFSET = 8'h08;
   localparam logic [7:0] SEL3_OFFSET = 8'h0c;
   localparam logic [7:0] STATUS_OFFSET = 8'h10;

   // Field positions in the sync control register.
   localparam int SYNC_PSR_BIT = 0;
   localparam int ASYNC_PSR_BIT = 1;
   localparam int HOLD_MODE_BIT = 7;

   // Reset values.
   localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
   localparam logic [2:0] SEL_RESET = 3'h0;

   // Prescaler width and tap positions (divide by 8, 64, 256, 1024).
   localparam int DIV_WIDTH = 10;
   localparam logic [9:0] TAP8_MASK = 10'h007;
   localparam logic [9:0] TAP64_MASK = 10'h03f;
   localparam logic [9:0] TAP256_MASK = 10'h0ff;
   localparam logic [9:0] TAP1024_MASK = 10'h3ff;
   localparam int NUM_TIMERS = 3;

   // Clock-select codes.
   typedef enum logic [2:0] {
      CS_STOP = 3'h0,
      CS_DIRECT = 3'h1,
      CS_DIV8 = 3'h2,
      CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4,
      CS_DIV1024 = 3'h5,
      CS_EXT_FALL = 3'h6,
      CS_EXT_RISE = 3'h7
   } clock_select_code_t;

   // Prescaler taps travel together.
   typedef struct packed {
      logic div8;
      logic div64;
      logic div256;
      logic div1024;
   } tap_set_t;

endpackage : prescaler_pkg

// file: core/ext_pin_sync.sv
// Synchronizer and edge detector for one external count pin.
// Assumes the pin is sampled on the single system clock.
`timescale 1ns/1ps
module ext_pin_sync (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // Two-stage sampler stands in for the latch and flip-flop pair; only the second stage is used.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Edge detection from the synchronized value only.
   assign rise_o = sync_r & ~prev_r;
   assign fall_o = ~sync_r & prev_r;
endmodule : ext_pin_sync

// file: core/prescaler_div.sv
// Shared free-running prescaler divider with a synchronous reset input.
// Assumes one system clock; taps are one-cycle enable pulses.
`timescale 1ns/1ps
module prescaler_div (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   output prescaler_pkg::tap_set_t taps_o
);
   logic [prescaler_pkg::DIV_WIDTH-1:0] count_r;

   // Counter runs at all times except while held by a prescaler reset.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         count_r <= '0;
      else if (clear_i)
         count_r <= '0;
      else
         count_r <= count_r + 1'b1;
   end

   // Each tap pulses once per wrap of its low bits.
   always_comb
   begin
      taps_o.div8 = ~clear_i && ((count_r & prescaler_pkg::TAP8_MASK) == prescaler_pkg::TAP8_MASK);
      taps_o.div64 = ~clear_i && ((count_r & prescaler_pkg::TAP64_MASK) == prescaler_pkg::TAP64_MASK);
      taps_o.div256 = ~clear_i && ((count_r & prescaler_pkg::TAP256_MASK) == prescaler_pkg::TAP256_MASK);
      taps_o.div1024 = ~clear_i && ((count_r & prescaler_pkg::TAP1024_MASK) == prescaler_pkg::TAP1024_MASK);
   end
endmodule : prescaler_div

// file: core/timer_prescaler_clock_select.sv
// Timer prescaler and clock-select front end with an APB register slave.
// Assumes one 50 MHz clock; the timer counters consume the tick outputs.
`timescale 1ns/1ps
module timer_prescaler_clock_select (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic timer0_ext_count_pin_i,
   input wire logic timer1_ext_count_pin_i,
   output logic timer0_tick_o,
   output logic timer1_tick_o,
   output logic timer3_tick_o,
   output logic async_prescaler_reset_o
);
   logic sync_hold_mode_r;
   logic sync_prescaler_reset_r;
   logic async_prescaler_reset_r;
   logic [2:0] sel_r [prescaler_pkg::NUM_TIMERS];
   logic [prescaler_pkg::NUM_TIMERS-1:0] tick_r;
   logic [prescaler_pkg::NUM_TIMERS-1:0] rise_w;
   logic [prescaler_pkg::NUM_TIMERS-1:0] fall_w;
   logic [prescaler_pkg::NUM_TIMERS-1:0] ext_pin_w;
   prescaler_pkg::tap_set_t taps_w;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic ctrl_wr;
   logic [31:0] rdata_nxt;

   // APB access decode; slave answers in the first access cycle.
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & penable_i & ~pwrite_i;
   assign ctrl_wr = wr_en && (paddr_i == prescaler_pkg::SYNC_CTRL_OFFSET);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;

   // Address check for mapped registers.
   always_comb
   begin
      unique case (paddr_i)
         prescaler_pkg::SYNC_CTRL_OFFSET, prescaler_pkg::SEL0_OFFSET, prescaler_pkg::SEL1_OFFSET,
         prescaler_pkg::SEL3_OFFSET, prescaler_pkg::STATUS_OFFSET: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Sync control: hold mode, sync prescaler reset and async prescaler reset bits.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync_hold_mode_r <= prescaler_pkg::SYNC_CTRL_RESET[prescaler_pkg::HOLD_MODE_BIT];
         sync_prescaler_reset_r <= prescaler_pkg::SYNC_CTRL_RESET[prescaler_pkg::SYNC_PSR_BIT];
         async_prescaler_reset_r <= prescaler_pkg::SYNC_CTRL_RESET[prescaler_pkg::ASYNC_PSR_BIT];
      end
      else if (ctrl_wr)
      begin
         sync_hold_mode_r <= pwdata_i[prescaler_pkg::HOLD_MODE_BIT];
         if (pwdata_i[prescaler_pkg::HOLD_MODE_BIT])
         begin
            sync_prescaler_reset_r <= pwdata_i[prescaler_pkg::SYNC_PSR_BIT];
            async_prescaler_reset_r <= pwdata_i[prescaler_pkg::ASYNC_PSR_BIT];
         end
         else
         begin
            // A write with hold mode off pulses the reset for one cycle, then clears.
            sync_prescaler_reset_r <= pwdata_i[prescaler_pkg::SYNC_PSR_BIT];
            async_prescaler_reset_r <= pwdata_i[prescaler_pkg::ASYNC_PSR_BIT];
         end
      end
      else if (!sync_hold_mode_r)
      begin
         sync_prescaler_reset_r <= 1'b0;
         async_prescaler_reset_r <= 1'b0;
      end
   end

   // Per-timer clock-select registers.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sel_r[0] <= prescaler_pkg::SEL_RESET;
         sel_r[1] <= prescaler_pkg::SEL_RESET;
         sel_r[2] <= prescaler_pkg::SEL_RESET;
      end
      else if (wr_en)
      begin
         if (paddr_i == prescaler_pkg::SEL0_OFFSET)
            sel_r[0] <= pwdata_i[2:0];
         if (paddr_i == prescaler_pkg::SEL1_OFFSET)
            sel_r[1] <= pwdata_i[2:0];
         if (paddr_i == prescaler_pkg::SEL3_OFFSET)
            sel_r[2] <= pwdata_i[2:0];
      end
   end

   // Read data mux.
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr_i)
         prescaler_pkg::SYNC_CTRL_OFFSET:
         begin
            rdata_nxt[prescaler_pkg::HOLD_MODE_BIT] = sync_hold_mode_r;
            rdata_nxt[prescaler_pkg::SYNC_PSR_BIT] = sync_prescaler_reset_r;
            rdata_nxt[prescaler_pkg::ASYNC_PSR_BIT] = async_prescaler_reset_r;
         end
         prescaler_pkg::SEL0_OFFSET: rdata_nxt[2:0] = sel_r[0];
         prescaler_pkg::SEL1_OFFSET: rdata_nxt[2:0] = sel_r[1];
         prescaler_pkg::SEL3_OFFSET: rdata_nxt[2:0] = sel_r[2];
         prescaler_pkg::STATUS_OFFSET: rdata_nxt[2:0] = tick_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data is registered in the setup cycle so it is stable in the access cycle.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i & ~penable_i & ~pwrite_i)
         prdata_o <= rdata_nxt;
      else if (rd_en)
         prdata_o <= prdata_o;
   end

   // One shared divider; held while the sync reset bit is set.
   prescaler_div u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clear_i(sync_prescaler_reset_r),
      .taps_o(taps_w)
   );

   // Timer 3 has no pin, so its edge detector input is tied low.
   assign ext_pin_w = {1'b0, timer1_ext_count_pin_i, timer0_ext_count_pin_i};

   // Per-timer synchronizer and clock-select tick generation.
   genvar g;
   generate
      for (g = 0; g < prescaler_pkg::NUM_TIMERS; g++)
      begin : g_timer
         logic tick_nxt;

         ext_pin_sync u_sync (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .pin_i(ext_pin_w[g]),
            .rise_o(rise_w[g]),
            .fall_o(fall_w[g])
         );

         // Select the tick source; prescaled ticks are gated while the prescaler is held.
         always_comb
         begin
            unique case (prescaler_pkg::clock_select_code_t'(sel_r[g]))
               prescaler_pkg::CS_STOP: tick_nxt = 1'b0;
               prescaler_pkg::CS_DIRECT: tick_nxt = ~sync_prescaler_reset_r;
               prescaler_pkg::CS_DIV8: tick_nxt = taps_w.div8;
               prescaler_pkg::CS_DIV64: tick_nxt = taps_w.div64;
               prescaler_pkg::CS_DIV256: tick_nxt = taps_w.div256;
               prescaler_pkg::CS_DIV1024: tick_nxt = taps_w.div1024;
               prescaler_pkg::CS_EXT_FALL: tick_nxt = (g != 2) && fall_w[g];
               prescaler_pkg::CS_EXT_RISE: tick_nxt = (g != 2) && rise_w[g];
            endcase
         end

         // Registered tick: pin edge to tick is three edges, matching the counter update window.
         always_ff @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
               tick_r[g] <= 1'b0;
            else
               tick_r[g] <= tick_nxt;
         end
      end
   endgenerate

   assign timer0_tick_o = tick_r[0];
   assign timer1_tick_o = tick_r[1];
   assign timer3_tick_o = tick_r[2];
   assign async_prescaler_reset_o = async_prescaler_reset_r;
endmodule : timer_prescaler_clock_select

// file: bench/ext_count_source.sv
// Model of the external clock source that drives the count pins.
// Assumes the bench clock; the pin stands still while run_i is low.
`timescale 1ns/1ps
module ext_count_source #(parameter int HALF = 3) (
   input wire logic clk_i,
   input wire logic run_i,
   output logic pin_o
);
   int cnt_r;
   initial
   begin
      pin_o = 1'b0;
      cnt_r = 0;
   end
   // Toggles every HALF cycles, so each half period spans several system cycles.
   always @(posedge clk_i)
   begin
      if (!run_i)
         cnt_r <= 0;
      else if (cnt_r == HALF - 1)
      begin
         cnt_r <= 0;
         pin_o <= !pin_o;
      end
      else
         cnt_r <= cnt_r + 1;
   end
endmodule : ext_count_source

// file: bench/prescale_monitor.sv
// Checker for the prescaler and clock-select block.
// Sees only the top ports and shadows the select codes from APB writes.
`timescale 1ns/1ps
module prescale_monitor (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic timer0_ext_count_pin_i,
   input wire logic timer1_ext_count_pin_i,
   input wire logic timer0_tick_o,
   input wire logic timer1_tick_o,
   input wire logic timer3_tick_o,
   input wire logic async_prescaler_reset_o
);
   logic [2:0] s0_r, s1_r, s3_r;
   logic wr, wr0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // A completed write and a write to the sync control word.
   assign wr = psel_i && penable_i && pwrite_i && pready_o;
   assign wr0 = wr && paddr_i == 8'h00;
   // Shadow copies of the three select codes.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s0_r <= 3'h0;
         s1_r <= 3'h0;
         s3_r <= 3'h0;
      end
      else if (wr)
      begin
         if (paddr_i == 8'h04) s0_r <= pwdata_i[2:0];
         if (paddr_i == 8'h08) s1_r <= pwdata_i[2:0];
         if (paddr_i == 8'h0c) s3_r <= pwdata_i[2:0];
      end
   end
   stop_no_tick_a: assert property ($past(s0_r) == 3'h0 && s0_r == 3'h0 |-> !timer0_tick_o)
      else $error("Timer 0 ticked while stopped.");
   t3_no_ext_a: assert property ($past(s3_r) >= 3'h6 && s3_r >= 3'h6 |-> !timer3_tick_o)
      else $error("Timer 3 ticked from a pin.");
   rise_latency_a: assert property (s0_r == 3'h7 && $past(s0_r) == 3'h7 && $rose(timer0_ext_count_pin_i)
      |-> ##3 timer0_tick_o) else $error("Rising pin edge gave no tick.");
   fall_latency_a: assert property (s1_r == 3'h6 && $past(s1_r) == 3'h6 && $fell(timer1_ext_count_pin_i)
      |-> ##3 timer1_tick_o) else $error("Falling pin edge gave no tick.");
   ext_edge_only_a: assert property (timer0_tick_o && s0_r == 3'h7 && $past(s0_r, 4) == 3'h7
      |-> $past(timer0_ext_count_pin_i, 3) && !$past(timer0_ext_count_pin_i, 4))
      else $error("External tick without a synchronized edge.");
   shared_phase_a: assert property (s0_r == s1_r && $past(s0_r) == $past(s1_r) && s0_r inside {[2:5]}
      |-> timer0_tick_o == timer1_tick_o) else $error("Shared taps out of phase.");
   div8_gap_a: assert property (timer0_tick_o && s0_r == 3'h2 && $past(s0_r) == 3'h2
      |=> !timer0_tick_o [*7]) else $error("Divide by 8 tick too soon.");
   hold_keep_a: assert property (wr0 && pwdata_i[7] && pwdata_i[1] |-> ##[1:2] async_prescaler_reset_o)
      else $error("Held reset bit not kept.");
   hold_clear_a: assert property (wr0 && !pwdata_i[7] |-> ##[1:3] !async_prescaler_reset_o)
      else $error("Reset bit not cleared with hold off.");
   cover property (timer0_tick_o && s0_r == 3'h7);
   cover property (timer1_tick_o && s1_r == 3'h5);
   cover property (async_prescaler_reset_o);
endmodule : prescale_monitor
bind timer_prescaler_clock_select prescale_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .timer0_ext_count_pin_i(timer0_ext_count_pin_i), .timer1_ext_count_pin_i(timer1_ext_count_pin_i),
   .timer0_tick_o(timer0_tick_o), .timer1_tick_o(timer1_tick_o), .timer3_tick_o(timer3_tick_o),
   .async_prescaler_reset_o(async_prescaler_reset_o));

// file: bench/tb_timer_prescaler_clock_select.sv
// Self-checking bench for the prescaler and clock-select block.
// Assumes a zero or longer wait APB slave and one pin source on both count pins.
`timescale 1ns/1ps
module tb_timer_prescaler_clock_select;
   logic clk_i, reset_i, psel_i, penable_i, pwrite_i, run, pin, pin_q, t0, t1, t3, apr, err, pready_o, pslverr_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   int error_cnt, checks_done, n0, n1, n3, nr, nf, a, b, c, d, e;
   int divs [4] = '{8, 64, 256, 1024};
   ext_count_source u_src (.clk_i(clk_i), .run_i(run), .pin_o(pin));
   timer_prescaler_clock_select u_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .timer0_ext_count_pin_i(pin), .timer1_ext_count_pin_i(pin), .timer0_tick_o(t0),
      .timer1_tick_o(t1), .timer3_tick_o(t3), .async_prescaler_reset_o(apr));
   // Counts ticks and pin edges seen at each rising clock edge.
   always @(posedge clk_i)
   begin
      pin_q <= pin;
      if (t0 === 1'b1) n0 <= n0 + 1;
      if (t1 === 1'b1) n1 <= n1 + 1;
      if (t3 === 1'b1) n3 <= n3 + 1;
      if (pin && !pin_q) nr <= nr + 1;
      if (!pin && pin_q) nf <= nf + 1;
   end
   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   // Compares one value and counts the result.
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // Waits for the next timer 1 tick and returns the cycles spent.
   task automatic wait_t1(output int cy);
      cy = 0;
      do
      begin
         @(posedge clk_i);
         cy++;
      end
      while (t1 !== 1'b1 && cy < 2000);
   endtask : wait_t1
   task print_verdict;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Cuts a hang short well after the tests should have ended.
   initial
   begin
      #300000;
      error_cnt++;
      $display("BAD at %0t: watchdog expired", $time);
      print_verdict();
   end
   // Main sequence of register calls and expected values.
   initial
   begin
      {reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, run} = {1'b1, 44'h0};
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      for (a = 0; a < 5; a++)
      begin
         apb(1'b0, 8'(4 * a), 32'h0);
         chk({err, rd}, 33'h0);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      chk(n0 + n1 + n3, 0);
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h0c, 32'h1);
      repeat (3) @(posedge clk_i);
      {a, b} = {n0, n3};
      repeat (20) @(posedge clk_i);
      chk(n0 - a, 20);
      chk(n3 - b, 20);
      for (a = 2; a < 6; a++)
      begin
         apb(1'b1, 8'h08, a);
         wait_t1(b);
         chk(b <= divs[a - 2] + 3, 1);
         wait_t1(b);
         chk(b, divs[a - 2]);
      end
      apb(1'b1, 8'h04, 32'h2);
      apb(1'b1, 8'h08, 32'h2);
      apb(1'b1, 8'h00, 32'h1);
      // Skip the tick that the old phase may still have in flight.
      @(posedge clk_i);
      wait_t1(b);
      chk(b >= 8 && b <= 11, 1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h00, 32'h83);
      apb(1'b0, 8'h00, 32'h0);
      chk({apr, rd}, {1'b1, 32'h83});
      a = n0 + n1;
      repeat (40) @(posedge clk_i);
      chk(n0 + n1 - a, 0);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk({apr, rd}, 33'h0);
      wait_t1(b);
      chk(t0, 1);
      apb(1'b1, 8'h04, 32'h7);
      apb(1'b1, 8'h08, 32'h6);
      apb(1'b1, 8'h0c, 32'h7);
      repeat (4) @(posedge clk_i);
      {a, b, c, d, e} = {n0, n1, nr, nf, n3};
      run <= 1'b1;
      repeat (60) @(posedge clk_i);
      run <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk(n0 - a, nr - c);
      chk(n1 - b, nf - d);
      chk(nr - c > 5, 1);
      chk(n3 - e, 0);
      print_verdict();
   end
endmodule : tb_timer_prescaler_clock_select
